// ===== design/rslv_core.sv
// reset source recording, low-voltage supervision and watchdog key decode
// assumes comparator and pin inputs are asynchronous; requests from logic
// on ref_clk arrive already synchronous; apb master on ref_clk
// What this block does
// - detector runs only while its enable bit is one
// - entering stop turns detector off unless stop-enable bit set
// - both bits set refuses deep stop; light stop allowed, detector kept
// - reset asserted whenever power-on comparator reports supply below rearm
// - after power-on, reset held until supply above low threshold
// - after power-on, power-on and low-voltage flags read one
// - reset-enable bit one and detector trip gives system reset
// - threshold-select bit chooses which comparator result is used
// - after low-voltage reset, hold until supply above selected threshold
// - warning with interrupt enable sets warning flag and raises request
// - status is eight-bit read-only; bits two and zero read zero
// - debug-forced reset leaves all status flags cleared
// - watchdog enabled, status write other than keys gives watchdog reset
// - 0x55 then 0xaa clears watchdog counter; flags untouched
// - other resets clear power/low flags; bits six..three follow sources
// - bit six flags external active-low pin reset
// - bit five flags watchdog reset; none while watchdog disabled
// - bit four flags illegal opcode incl. disallowed stop or background
// - bit three flags access to unimplemented address
// - bit seven flags power-on; bit one flags low-voltage or power-on
//
// The APB register port and the register offsets are this design's own decisions.
module rslv_core #(
    parameter logic [15:0] WDOG_TIMEOUT = rslv_pkg::WDOG_TIMEOUT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rslv_pkg::rslv_cmp_t cmp_async,
    input wire logic reset_pin_n_async,
    input wire logic watchdog_enable,
    input wire logic stop_allow,
    input wire logic background_debug_allow,
    input wire logic stop_exec,
    input wire logic background_instruction,
    input wire logic bad_opcode,
    input wire logic bad_address,
    input wire logic debug_write,
    input wire logic stop_request,
    input wire logic stop_deep,
    output logic stop_grant,
    output logic deep_stop_mode,
    output logic light_stop_mode,
    output logic lowv_detect_on,
    output logic lowv_warning_irq,
    output logic sys_reset
);
    // two-flop synchronisers on all analog and pin inputs
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 5'h1f;
            sync_b <= 5'h1f;
        end else if (clk_en) begin
            sync_a <= {cmp_async, ~reset_pin_n_async};
            sync_b <= sync_a;
        end
    end
    wire por_low = sync_b[4];
    wire below_low = sync_b[3];
    wire below_high = sync_b[2];
    wire warn_cmp = sync_b[1];
    wire pin_low = sync_b[0];

    logic [7:0] ctrl;
    logic [7:0] status;
    logic [15:0] wdog_cnt;
    logic key_armed;
    logic in_stop;
    logic in_deep;
    rslv_pkg::rslv_state_t state;
    rslv_pkg::rslv_state_t next_state;

    wire det_en = ctrl[rslv_pkg::CT_DET_EN];
    wire stop_en = ctrl[rslv_pkg::CT_STOP_EN];
    // detector off in stop unless kept running
    assign lowv_detect_on = det_en && (!in_stop || stop_en);
    // chosen threshold comparator result
    wire lowv_trip = ctrl[rslv_pkg::CT_THR_SEL] ? below_high : below_low;
    wire lowv_rst_req = lowv_detect_on && ctrl[rslv_pkg::CT_RST_EN] && lowv_trip;
    // a disabled detector or reset enable must not pin the part in reset after other sources
    wire lowv_hold = det_en && ctrl[rslv_pkg::CT_RST_EN] && lowv_trip;

    // bus decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire sel_status = paddr == rslv_pkg::ADDR_STATUS;
    wire sel_ctrl = paddr == rslv_pkg::ADDR_CTRL;
    wire sel_wdog = paddr == rslv_pkg::ADDR_WDOG;
    wire sel_debug = paddr == rslv_pkg::ADDR_DEBUG;
    wire mapped = sel_status || sel_ctrl || sel_wdog || sel_debug;
    wire [7:0] wbyte = pwdata[7:0];
    wire st_wr = wr && sel_status;
    wire is_key1 = wbyte == rslv_pkg::KEY_FIRST;
    wire is_key2 = wbyte == rslv_pkg::KEY_SECOND;
    // user writes to the debug register are ignored; only debug port counts
    wire dbg_force = debug_write && wr && sel_debug && pwdata[rslv_pkg::DEBUG_FORCE_BIT];
    wire bad_key = st_wr && watchdog_enable && !is_key1 && !is_key2;
    wire service = st_wr && is_key2 && key_armed;
    wire wdog_expire = watchdog_enable && (wdog_cnt == WDOG_TIMEOUT);
    wire wdog_req = wdog_expire || bad_key;
    wire opc_req = bad_opcode || (stop_exec && !stop_allow)
        || (background_instruction && !background_debug_allow);
    wire run = state == rslv_pkg::RSLV_RUN;
    wire other_req = pin_low || wdog_req || opc_req || bad_address || dbg_force;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    wire [7:0] ctrl_rd = {1'b0, ctrl[6:0]} & 8'h3f;
    wire [31:0] rd_mux = !(psel && !pwrite) ? 32'h0 :
        sel_status ? {24'h0, status & 8'hfa} :
        sel_ctrl ? {24'h0, ctrl_rd} :
        sel_wdog ? {16'h0, wdog_cnt} : 32'h0;
    // loaded at the setup edge, so read data leaves a flop yet needs no wait state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) prdata <= 32'h0;
        else if (clk_en && psel && !penable) prdata <= rd_mux;
    end

    // stop mode gating
    wire deep_refused = det_en && stop_en;
    assign stop_grant = stop_request && stop_allow && !(stop_deep && deep_refused) && run;
    assign deep_stop_mode = in_stop && in_deep;
    assign light_stop_mode = in_stop && !in_deep;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_stop <= 1'b0;
            in_deep <= 1'b0;
        end else if (clk_en) begin
            if (stop_grant) begin
                in_stop <= 1'b1;
                in_deep <= stop_deep;
            end else if (!stop_request || !run) begin
                in_stop <= 1'b0;
            end
        end
    end

    // reset sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            rslv_pkg::RSLV_POR: if (!por_low && !below_low) next_state = rslv_pkg::RSLV_RUN;
            rslv_pkg::RSLV_HOLD: if (por_low) next_state = rslv_pkg::RSLV_POR;
                else if (!lowv_hold && !other_req) next_state = rslv_pkg::RSLV_RUN;
            rslv_pkg::RSLV_RUN: if (por_low) next_state = rslv_pkg::RSLV_POR;
                else if (lowv_rst_req || other_req) next_state = rslv_pkg::RSLV_HOLD;
            default: next_state = rslv_pkg::RSLV_POR;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) state <= rslv_pkg::RSLV_POR;
        else if (clk_en) state <= next_state;
    end
    assign sys_reset = !run;

    // status capture at reset entry
    wire [7:0] other_flags = {1'b0, pin_low, wdog_req, opc_req, bad_address, 3'b000};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status <= rslv_pkg::STATUS_POR_VALUE;
        end else if (clk_en) begin
            if (state != rslv_pkg::RSLV_POR && por_low) begin
                status <= rslv_pkg::STATUS_POR_VALUE;
            end else if (run && lowv_rst_req) begin
                status <= {status[rslv_pkg::ST_POR], 5'h00, 2'b10};
            end else if (run && dbg_force) begin
                status <= 8'h00;
            end else if (run && other_req) begin
                status <= other_flags;
            end
        end
    end

    // watchdog counter and key state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdog_cnt <= 16'h0;
            key_armed <= 1'b0;
        end else if (clk_en) begin
            if (!run || service || !watchdog_enable) wdog_cnt <= 16'h0;
            else if (!wdog_expire) wdog_cnt <= wdog_cnt + 16'h1;
            if (!run) key_armed <= 1'b0;
            else if (st_wr) key_armed <= is_key1;
        end
    end

    // control register and warning flag
    wire warn_set = lowv_detect_on && warn_cmp && ctrl[rslv_pkg::CT_WARN_IE];
    wire warn_clr = wr && sel_ctrl && pwdata[rslv_pkg::CT_WARN_ACK];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= rslv_pkg::CTRL_RESET;
        end else if (clk_en) begin
            if (wr && sel_ctrl) ctrl[4:0] <= wbyte[4:0];
            // set wins over a same-cycle acknowledge
            if (warn_set) ctrl[rslv_pkg::CT_WARN_FLAG] <= 1'b1;
            else if (warn_clr) ctrl[rslv_pkg::CT_WARN_FLAG] <= 1'b0;
        end
    end
    assign lowv_warning_irq = ctrl[rslv_pkg::CT_WARN_FLAG] && ctrl[rslv_pkg::CT_WARN_IE];
endmodule

// ===== design/rslv_pkg.sv
// package for the reset source and low-voltage control block
// assumes apb with 32-bit data, one aligned word per register
package rslv_pkg;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_WDOG = 12'h008;
    localparam logic [11:0] ADDR_DEBUG = 12'h00c;
    // status bit positions
    localparam int ST_POR = 7;
    localparam int ST_PIN = 6;
    localparam int ST_WDOG = 5;
    localparam int ST_OPC = 4;
    localparam int ST_ADR = 3;
    localparam int ST_LOWV = 1;
    localparam logic [7:0] STATUS_POR_VALUE = 8'h82;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // control bit positions
    localparam int CT_DET_EN = 0;
    localparam int CT_STOP_EN = 1;
    localparam int CT_RST_EN = 2;
    localparam int CT_THR_SEL = 3;
    localparam int CT_WARN_IE = 4;
    localparam int CT_WARN_FLAG = 5;
    localparam int CT_WARN_ACK = 6;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [15:0] WDOG_TIMEOUT_DEFAULT = 16'h0400;
    localparam int DEBUG_FORCE_BIT = 0;

    typedef struct packed {
        logic pin_low;
        logic wdog_timeout;
        logic bad_opcode;
        logic bad_address;
        logic debug_force;
    } rslv_req_t;

    typedef struct packed {
        logic por_low;
        logic lowv_low_thr;
        logic lowv_high_thr;
        logic lowv_warn;
    } rslv_cmp_t;

    typedef enum logic [2:0] {
        RSLV_RUN = 3'b001,
        RSLV_HOLD = 3'b010,
        RSLV_POR = 3'b100
    } rslv_state_t;
endpackage

// ===== sim/rslv_monitor.sv
// concurrent checks on the reset source block ports
// assumes one clock domain, bound onto every rslv_core
module rslv_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire rslv_pkg::rslv_cmp_t cmp_async,
    input wire logic reset_pin_n_async,
    input wire logic watchdog_enable,
    input wire logic stop_allow,
    input wire logic stop_request,
    input wire logic stop_grant,
    input wire logic bad_opcode,
    input wire logic bad_address,
    input wire logic sys_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence stat_acc;
        psel && penable && paddr == rslv_pkg::ADDR_STATUS;
    endsequence
    sequence bad_key;
        stat_acc ##0 pwrite && watchdog_enable && pwdata[7:0] != rslv_pkg::KEY_FIRST
            && pwdata[7:0] != rslv_pkg::KEY_SECOND;
    endsequence
    // two sync flops plus the state register
    AST_POR_RESET: assert property (cmp_async.por_low |-> ##[1:4] sys_reset)
        else $error("no reset on low supply");
    AST_PIN_RESET: assert property ($fell(reset_pin_n_async) |-> ##[1:5] sys_reset) else $error("pin ignored");
    AST_OPC_RESET: assert property (bad_opcode |-> ##[1:2] sys_reset) else $error("bad opcode ignored");
    AST_ADR_RESET: assert property (bad_address |-> ##[1:2] sys_reset) else $error("bad address ignored");
    AST_KEY_RESET: assert property (bad_key |-> ##[1:2] sys_reset) else $error("bad key ignored");
    AST_STAT_ZERO: assert property (stat_acc ##0 !pwrite |->
        prdata[31:8] == 24'h0 && prdata[2] == 1'b0 && prdata[0] == 1'b0) else $error("status spare bits set");
    AST_UNMAPPED: assert property (psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    AST_STOP_GRANT: assert property (stop_grant |-> stop_allow && stop_request && !sys_reset)
        else $error("stop granted while disallowed");
endmodule
bind rslv_core rslv_monitor rslv_monitor_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pslverr, .cmp_async, .reset_pin_n_async, .watchdog_enable, .stop_allow, .stop_request, .stop_grant, .bad_opcode,
    .bad_address, .sys_reset);

// ===== sim/rslv_supply.sv
// supply comparators and reset pin seen by the reset block
// lvl: 0 below rearm, 1 below low threshold, 2 below high, 3 good
module rslv_supply (
    input wire logic [1:0] lvl,
    input wire logic pin_hold,
    output rslv_pkg::rslv_cmp_t cmp,
    output logic reset_pin_n
);
    assign cmp = {lvl == 2'h0, lvl < 2'h2, lvl < 2'h3, lvl < 2'h3};
    // pin has a pull-up, so released reads high
    assign reset_pin_n = !pin_hold;
endmodule

// ===== sim/rslv_core_bench.sv
// register-level tests of the reset source block
// assumes an apb slave that may add wait states and a 64-cycle watchdog
module rslv_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_write = 1'b0;
    logic watchdog_enable = 1'b0, stop_allow = 1'b0, stop_request = 1'b0, stop_deep = 1'b0, pin = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, stop_grant, irq, sys_reset, det_on, pin_n, deep_mode, light_mode, err;
    logic [3:0] rq = 4'h0;
    logic [1:0] lvl = 2'h3;
    rslv_pkg::rslv_cmp_t cmp;
    int n_errors = 0, compares = 0, cyc = 0, i;
    localparam logic [7:0] EXP[4] = '{8'h10, 8'h08, 8'h10, 8'h10};
    rslv_supply rslv_supply_i (.lvl, .pin_hold(pin), .cmp, .reset_pin_n(pin_n));
    rslv_core #(.WDOG_TIMEOUT(16'h0040)) rslv_core_i (.ref_clk, .rst, .clk_en(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_async(cmp), .reset_pin_n_async(pin_n), .watchdog_enable,
        .stop_allow, .background_debug_allow(1'b0), .stop_exec(rq[2]), .background_instruction(rq[3]),
        .bad_opcode(rq[0]), .bad_address(rq[1]), .debug_write, .stop_request, .stop_deep, .stop_grant,
        .deep_stop_mode(deep_mode), .light_stop_mode(light_mode), .lowv_detect_on(det_on),
        .lowv_warning_irq(irq), .sys_reset);
    initial forever #5 ref_clk = ~ref_clk;
    task results;
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (!pready) @(posedge ref_clk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits for a reset pulse to come and go, then reads status
    task rcyc;
        int k;
        k = 0;
        while (!sys_reset && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
        while (sys_reset && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        acc(1'b0, rslv_pkg::ADDR_STATUS, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rcyc();
        chk("status", r, 32'h82);
        acc(1'b0, rslv_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", r, 32'h01);
        acc(1'b0, 12'h010, 32'h0);
        chk("unmapped", r, 32'h0);
        chk("pslverr", err, 32'h1);
        watchdog_enable <= 1'b1;
        acc(1'b1, rslv_pkg::ADDR_STATUS, 32'h55);
        acc(1'b1, rslv_pkg::ADDR_STATUS, 32'haa);
        acc(1'b0, rslv_pkg::ADDR_STATUS, 32'h0);
        chk("status", r, 32'h82);
        repeat (40) @(posedge ref_clk);
        acc(1'b1, rslv_pkg::ADDR_STATUS, 32'haa);
        acc(1'b0, rslv_pkg::ADDR_WDOG, 32'h0);
        chk("lone key count", {31'h0, r[15:0] > 16'h0014}, 32'h1);
        rcyc();
        chk("status", r, 32'h20);
        acc(1'b1, rslv_pkg::ADDR_STATUS, 32'h12);
        rcyc();
        chk("status", r, 32'h20);
        watchdog_enable <= 1'b0;
        acc(1'b1, rslv_pkg::ADDR_STATUS, 32'h12);
        repeat (4) @(posedge ref_clk);
        chk("sys_reset", sys_reset, 32'h0);
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            rq[i] <= 1'b1;
            @(posedge ref_clk);
            rq[i] <= 1'b0;
            rcyc();
            chk("status", r, {24'h0, EXP[i]});
        end
        pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        pin <= 1'b0;
        rcyc();
        chk("status", r, 32'h40);
        debug_write <= 1'b1;
        acc(1'b1, rslv_pkg::ADDR_DEBUG, 32'h1);
        debug_write <= 1'b0;
        rcyc();
        chk("status", r, 32'h0);
        for (i = 0; i < 2; i++) begin
            acc(1'b1, rslv_pkg::ADDR_CTRL, i ? 32'h0d : 32'h05);
            lvl <= i ? 2'h2 : 2'h1;
            repeat (30) @(posedge ref_clk);
            chk("sys_reset", sys_reset, 32'h1);
            lvl <= 2'h3;
            rcyc();
            chk("status", r, 32'h02);
        end
        lvl <= 2'h0;
        repeat (10) @(posedge ref_clk);
        lvl <= 2'h1;
        repeat (20) @(posedge ref_clk);
        chk("sys_reset", sys_reset, 32'h1);
        lvl <= 2'h3;
        rcyc();
        chk("status", r, 32'h82);
        acc(1'b1, rslv_pkg::ADDR_CTRL, 32'h11);
        lvl <= 2'h2;
        repeat (6) @(posedge ref_clk);
        chk("irq", irq, 32'h1);
        acc(1'b0, rslv_pkg::ADDR_CTRL, 32'h0);
        chk("warn flag", r[5], 32'h1);
        lvl <= 2'h3;
        acc(1'b1, rslv_pkg::ADDR_CTRL, 32'h51);
        acc(1'b0, rslv_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", r, 32'h11);
        stop_allow <= 1'b1;
        acc(1'b1, rslv_pkg::ADDR_CTRL, 32'h03);
        stop_request <= 1'b1;
        stop_deep <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("deep grant", stop_grant, 32'h0);
        stop_deep <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("light grant", stop_grant, 32'h1);
        chk("detector", det_on, 32'h1);
        chk("light mode", light_mode, 32'h1);
        acc(1'b1, rslv_pkg::ADDR_CTRL, 32'h01);
        @(posedge ref_clk);
        chk("detector", det_on, 32'h0);
        stop_deep <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("deep mode", deep_mode, 32'h1);
        results();
    end
endmodule
